/* File: design/sss_pkg.sv */
package sss_pkg;

	////////////////////////////////////////////////////////////////////////
	// register byte offsets
	localparam logic [7:0] OFF_STATUS   = 8'h00;
	localparam logic [7:0] OFF_IRQ_EN   = 8'h04;
	localparam logic [7:0] OFF_IRQ_DIS  = 8'h08;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h0C;
	localparam logic [7:0] OFF_CTRL     = 8'h10;
	localparam logic [7:0] OFF_WORD_SEL = 8'hFC;

	////////////////////////////////////////////////////////////////////////
	// status and mask bit positions
	localparam int BIT_TX_HOLDING_FREE    = 0;
	localparam int BIT_TX_ALL_SENT        = 1;
	localparam int BIT_TX_COUNT_DONE      = 2;
	localparam int BIT_TX_COUNTERS_ZERO   = 3;
	localparam int BIT_RX_WORD_AVAILABLE  = 4;
	localparam int BIT_RX_OVERRUN_FLAG    = 5;
	localparam int BIT_RX_COUNT_DONE      = 6;
	localparam int BIT_RX_COUNTERS_ZERO   = 7;
	localparam int BIT_TX_FRAME_SYNC_SEEN = 10;
	localparam int BIT_RX_FRAME_SYNC_SEEN = 11;
	localparam int BIT_TRANSMITTER_ON     = 16;
	localparam int BIT_RECEIVER_ON        = 17;

	// control register bit positions
	localparam int BIT_CTRL_TX_ON   = 0;
	localparam int BIT_CTRL_RX_ON   = 1;
	localparam int BIT_CTRL_FS_EDGE = 24;

	////////////////////////////////////////////////////////////////////////
	// masks and reset values
	localparam logic [31:0] IRQ_BITS      = 32'h00000CFF;
	localparam logic [31:0] CTRL_BITS     = 32'h01000003;
	localparam logic [31:0] MASK_RESET    = 32'h00000000;
	localparam logic [31:0] CTRL_RESET    = 32'h00000000;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;

	// frame sync edge encodings
	localparam logic EDGE_RISE = 1'h0;
	localparam logic EDGE_FALL = 1'h1;

	////////////////////////////////////////////////////////////////////////
	// carriers
	localparam int DMA_CNT_W = 16;

	typedef struct packed {
		logic [DMA_CNT_W-1:0] count;
		logic [DMA_CNT_W-1:0] next_count;
		logic                 count_wr;
		logic                 next_wr;
	} sss_dma_s;

	typedef struct packed {
		logic holding_full;
		logic shifting;
	} sss_tx_s;

	typedef struct packed {
		logic word_load;
		logic word_read;
	} sss_rx_s;

endpackage : sss_pkg

/* File: design/sss_sync_edge.sv */
`timescale 1ns/1ns
`default_nettype none

module sss_sync_edge (
	// clock and reset
	input  wire  logic aclk,
	input  wire  logic aresetn,
	input  wire  logic ce,
	// frame sync level and edge choice
	input  wire  logic sync_level,
	input  wire  logic edge_sel,
	// detected edge
	output logic       edge_pulse
);

	logic prev_q;
	logic rise;
	logic fall;

	assign rise       = sync_level & ~prev_q;
	assign fall       = ~sync_level & prev_q;
	assign edge_pulse = (edge_sel == sss_pkg::EDGE_FALL) ? fall : rise;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prev_q <= 1'b0;
		end else if (ce) begin
			prev_q <= sync_level;
		end
	end

endmodule : sss_sync_edge

`default_nettype wire

/* File: design/sss_status_irq.sv */
//
// Contract
// (R1) holding free flag low while data waits
// (R2) all sent only when shifted out completely
// (R3) tx count done once counter reached zero
// (R4) tx counters zero while both counters zero
// (R5) rx word available while holding register full
// (R6) overrun on reload unread; clear on read
// (R7) rx count done at zero; write clears
// (R8) rx counters zero while both counters zero
// (R9) tx sync sticky until status read
// (R10) rx sync sticky until status read
// (R11) bit 16 shows transmitter enable
// (R12) bit 17 shows receiver enable
// (R13) enable write sets written mask bits
// (R14) disable write clears written mask bits
// (R15) mask read returns enabled sources
// (R16) edge select: 0 rising, 1 falling (tx sync only; rx sync always uses the rising edge)
// (R17) irq when flag and mask; mask reset clear
// (R18) status read clears only sticky flags
//
// The AXI4-Lite interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ns
`default_nettype none

module sss_status_irq #(
	parameter int ADDR_W = 8
) (
	// clock, reset, enable
	input  wire  logic              aclk,
	input  wire  logic              aresetn,
	input  wire  logic              ce,
	// axi4-lite write address
	input  wire  logic              s_axi_awvalid,
	output logic                    s_axi_awready,
	input  wire  logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire  logic [2:0]        s_axi_awprot,
	// axi4-lite write data
	input  wire  logic              s_axi_wvalid,
	output logic                    s_axi_wready,
	input  wire  logic [31:0]       s_axi_wdata,
	input  wire  logic [3:0]        s_axi_wstrb,
	// axi4-lite write response
	output logic                    s_axi_bvalid,
	input  wire  logic              s_axi_bready,
	output logic [1:0]              s_axi_bresp,
	// axi4-lite read address
	input  wire  logic              s_axi_arvalid,
	output logic                    s_axi_arready,
	input  wire  logic [ADDR_W-1:0] s_axi_araddr,
	input  wire  logic [2:0]        s_axi_arprot,
	// axi4-lite read data
	output logic                    s_axi_rvalid,
	input  wire  logic              s_axi_rready,
	output logic [31:0]             s_axi_rdata,
	output logic [1:0]              s_axi_rresp,
	// shifter and holding register state
	input  wire  sss_pkg::sss_tx_s  tx_state,
	input  wire  sss_pkg::sss_rx_s  rx_state,
	// peripheral dma counters
	input  wire  sss_pkg::sss_dma_s tx_dma,
	input  wire  sss_pkg::sss_dma_s rx_dma,
	// frame sync levels
	input  wire  logic              tx_frame_sync,
	input  wire  logic              rx_frame_sync,
	// control outputs to the shifters
	output logic                    transmitter_on,
	output logic                    receiver_on,
	output logic                    frame_sync_edge_select,
	// interrupt
	output logic                    irq
);

	////////////////////////////////////////////////////////////////////////
	// declarations

	logic              aw_held_q;
	logic [ADDR_W-1:0] aw_addr_q;
	logic              w_held_q;
	logic [31:0]       w_data_q;
	logic [3:0]        w_strb_q;
	logic              bvalid_q;
	logic [1:0]        bresp_q;
	logic              rvalid_q;
	logic [31:0]       rdata_q;
	logic [1:0]        rresp_q;

	logic [31:0]       mask_q;
	logic [31:0]       mask_d;
	logic [31:0]       ctrl_q;
	logic [31:0]       ctrl_d;

	logic              tx_count_done_q;
	logic              rx_count_done_q;
	logic              tx_zero_prev_q;
	logic              rx_zero_prev_q;
	logic              rx_word_available_q;
	logic              rx_overrun_flag_q;
	logic              tx_frame_sync_seen_q;
	logic              rx_frame_sync_seen_q;

	logic              wr_fire;
	logic              rd_fire;
	logic [7:0]        wr_off;
	logic [7:0]        rd_off;
	logic [31:0]       wr_bits;
	logic              wr_status;
	logic              wr_irq_en;
	logic              wr_irq_dis;
	logic              wr_irq_mask;
	logic              wr_ctrl;
	logic              wr_mapped;
	logic              rd_status;
	logic              rd_irq_mask;
	logic              rd_ctrl;
	logic              rd_wo;
	logic              rd_mapped;
	logic [31:0]       rd_value;
	logic              status_clear;
	logic [31:0]       w1c_bits;

	logic              tx_holding_free;
	logic              tx_all_sent;
	logic              tx_counters_zero;
	logic              rx_counters_zero;
	logic              tx_count_zero;
	logic              rx_count_zero;
	logic              tx_zero_event;
	logic              rx_zero_event;
	logic              tx_sync_edge;
	logic              rx_sync_edge;
	logic              overrun_event;
	logic [31:0]       status;

	////////////////////////////////////////////////////////////////////////
	// axi handshakes

	assign s_axi_awready = ~aw_held_q & ~bvalid_q;
	assign s_axi_wready  = ~w_held_q & ~bvalid_q;
	assign s_axi_arready = ~rvalid_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;

	assign wr_fire = aw_held_q & w_held_q & ~bvalid_q;
	assign rd_fire = s_axi_arvalid & ~rvalid_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q <= 1'b0;
			aw_addr_q <= '0;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_held_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_q <= 1'b0;
			w_data_q <= '0;
			w_strb_q <= '0;
		end else if (ce) begin
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_held_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q  <= sss_pkg::RESP_OKAY;
		end else if (ce) begin
			if (wr_fire) begin
				bvalid_q <= 1'b1;
				bresp_q  <= wr_mapped ? sss_pkg::RESP_OKAY
				                      : sss_pkg::RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q  <= '0;
			rresp_q  <= sss_pkg::RESP_OKAY;
		end else if (ce) begin
			if (rd_fire) begin
				rvalid_q <= 1'b1;
				rdata_q  <= rd_value;
				rresp_q  <= rd_mapped ? sss_pkg::RESP_OKAY
				                      : sss_pkg::RESP_SLVERR;
			end else if (s_axi_rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// address decode

	assign wr_off      = aw_addr_q[7:0] & sss_pkg::OFF_WORD_SEL;
	assign rd_off      = s_axi_araddr[7:0] & sss_pkg::OFF_WORD_SEL;
	assign wr_bits     = w_data_q & {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
	                                 {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
	assign wr_status   = wr_fire & (wr_off == sss_pkg::OFF_STATUS);
	assign wr_irq_en   = wr_fire & (wr_off == sss_pkg::OFF_IRQ_EN);
	assign wr_irq_dis  = wr_fire & (wr_off == sss_pkg::OFF_IRQ_DIS);
	assign wr_irq_mask = wr_fire & (wr_off == sss_pkg::OFF_IRQ_MASK);
	assign wr_ctrl     = wr_fire & (wr_off == sss_pkg::OFF_CTRL);
	assign wr_mapped   = wr_status | wr_irq_en | wr_irq_dis
	                   | wr_irq_mask | wr_ctrl;

	assign rd_status   = rd_off == sss_pkg::OFF_STATUS;
	assign rd_irq_mask = rd_off == sss_pkg::OFF_IRQ_MASK;
	assign rd_ctrl     = rd_off == sss_pkg::OFF_CTRL;
	assign rd_wo       = (rd_off == sss_pkg::OFF_IRQ_EN)
	                   | (rd_off == sss_pkg::OFF_IRQ_DIS);
	assign rd_mapped   = rd_status | rd_irq_mask | rd_ctrl | rd_wo;
	assign rd_value    = rd_status   ? status :
	                     rd_irq_mask ? mask_q : // (R15)
	                     rd_ctrl     ? ctrl_q : 32'h00000000;

	// read of status, and write-one-to-clear of the sticky flags
	assign status_clear = rd_fire & rd_status; // (R18)
	assign w1c_bits     = wr_status ? wr_bits : 32'h00000000;

	////////////////////////////////////////////////////////////////////////
	// mask and control registers

	assign mask_d = wr_irq_en  ? (mask_q | (wr_bits & sss_pkg::IRQ_BITS)) :
	                wr_irq_dis ? (mask_q & ~wr_bits) : mask_q; // (R13) (R14)

	assign ctrl_d = wr_ctrl ? (wr_bits & sss_pkg::CTRL_BITS)
	                        | (ctrl_q & ~{{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
	                                     {8{w_strb_q[1]}}, {8{w_strb_q[0]}}}
	                                  & sss_pkg::CTRL_BITS)
	                        : ctrl_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mask_q <= sss_pkg::MASK_RESET; // (R17)
			ctrl_q <= sss_pkg::CTRL_RESET;
		end else if (ce) begin
			mask_q <= mask_d;
			ctrl_q <= ctrl_d;
		end
	end

	assign transmitter_on         = ctrl_q[sss_pkg::BIT_CTRL_TX_ON];
	assign receiver_on            = ctrl_q[sss_pkg::BIT_CTRL_RX_ON];
	assign frame_sync_edge_select = ctrl_q[sss_pkg::BIT_CTRL_FS_EDGE];

	////////////////////////////////////////////////////////////////////////
	// level flags

	assign tx_holding_free  = ~tx_state.holding_full; // (R1)
	assign tx_all_sent      = ~tx_state.holding_full
	                        & ~tx_state.shifting; // (R2)
	assign tx_count_zero    = tx_dma.count == '0;
	assign rx_count_zero    = rx_dma.count == '0;
	assign tx_counters_zero = tx_count_zero
	                        & (tx_dma.next_count == '0); // (R4)
	assign rx_counters_zero = rx_count_zero
	                        & (rx_dma.next_count == '0); // (R8)

	////////////////////////////////////////////////////////////////////////
	// counter end flags

	assign tx_zero_event = tx_count_zero & ~tx_zero_prev_q;
	assign rx_zero_event = rx_count_zero & ~rx_zero_prev_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_zero_prev_q  <= 1'b1;
			rx_zero_prev_q  <= 1'b1;
			tx_count_done_q <= 1'b0;
			rx_count_done_q <= 1'b0;
		end else if (ce) begin
			tx_zero_prev_q <= tx_count_zero;
			rx_zero_prev_q <= rx_count_zero;
			if (tx_zero_event) begin
				tx_count_done_q <= 1'b1; // (R3)
			end else if (tx_dma.count_wr || tx_dma.next_wr) begin
				tx_count_done_q <= 1'b0; // (R3)
			end
			if (rx_zero_event) begin
				rx_count_done_q <= 1'b1; // (R7)
			end else if (rx_dma.count_wr || rx_dma.next_wr) begin
				rx_count_done_q <= 1'b0; // (R7)
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// receive holding flags

	assign overrun_event = rx_state.word_load & rx_word_available_q
	                     & ~rx_state.word_read;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_word_available_q <= 1'b0;
			rx_overrun_flag_q   <= 1'b0;
		end else if (ce) begin
			if (rx_state.word_load) begin
				rx_word_available_q <= 1'b1; // (R5)
			end else if (rx_state.word_read) begin
				rx_word_available_q <= 1'b0; // (R5)
			end
			if (overrun_event) begin
				rx_overrun_flag_q <= 1'b1; // (R6)
			end else if (status_clear
			    || w1c_bits[sss_pkg::BIT_RX_OVERRUN_FLAG]) begin
				rx_overrun_flag_q <= 1'b0; // (R6)
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// frame sync flags

	sss_sync_edge u_tx_edge (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.ce         (ce),
		.sync_level (tx_frame_sync),
		.edge_sel   (frame_sync_edge_select), // (R16)
		.edge_pulse (tx_sync_edge)
	);

	sss_sync_edge u_rx_edge (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.ce         (ce),
		.sync_level (rx_frame_sync),
		.edge_sel   (sss_pkg::EDGE_RISE),
		.edge_pulse (rx_sync_edge)
	);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_frame_sync_seen_q <= 1'b0;
			rx_frame_sync_seen_q <= 1'b0;
		end else if (ce) begin
			if (tx_sync_edge) begin
				tx_frame_sync_seen_q <= 1'b1; // (R9)
			end else if (status_clear
			    || w1c_bits[sss_pkg::BIT_TX_FRAME_SYNC_SEEN]) begin
				tx_frame_sync_seen_q <= 1'b0; // (R9)
			end
			if (rx_sync_edge) begin
				rx_frame_sync_seen_q <= 1'b1; // (R10)
			end else if (status_clear
			    || w1c_bits[sss_pkg::BIT_RX_FRAME_SYNC_SEEN]) begin
				rx_frame_sync_seen_q <= 1'b0; // (R10)
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// status word and interrupt

	always_comb begin
		status = 32'h00000000;
		status[sss_pkg::BIT_TX_HOLDING_FREE]    = tx_holding_free;
		status[sss_pkg::BIT_TX_ALL_SENT]        = tx_all_sent;
		status[sss_pkg::BIT_TX_COUNT_DONE]      = tx_count_done_q;
		status[sss_pkg::BIT_TX_COUNTERS_ZERO]   = tx_counters_zero;
		status[sss_pkg::BIT_RX_WORD_AVAILABLE]  = rx_word_available_q;
		status[sss_pkg::BIT_RX_OVERRUN_FLAG]    = rx_overrun_flag_q;
		status[sss_pkg::BIT_RX_COUNT_DONE]      = rx_count_done_q;
		status[sss_pkg::BIT_RX_COUNTERS_ZERO]   = rx_counters_zero;
		status[sss_pkg::BIT_TX_FRAME_SYNC_SEEN] = tx_frame_sync_seen_q;
		status[sss_pkg::BIT_RX_FRAME_SYNC_SEEN] = rx_frame_sync_seen_q;
		status[sss_pkg::BIT_TRANSMITTER_ON]     = transmitter_on; // (R11)
		status[sss_pkg::BIT_RECEIVER_ON]        = receiver_on; // (R12)
	end

	assign irq = |(status & mask_q & sss_pkg::IRQ_BITS); // (R17)

	////////////////////////////////////////////////////////////////////////
	// unused protection bits

	logic unused_prot;
	assign unused_prot = ^{s_axi_awprot, s_axi_arprot};

endmodule : sss_status_irq

`default_nettype wire

/* File: verification/sss_status_irq_properties.sv */
`timescale 1ns/1ns
`default_nettype none

module sss_status_irq_chk #(
	parameter int ADDR_W = 8
) (
	// clock and reset
	input wire logic              aclk,
	input wire logic              aresetn,
	// bus
	input wire logic              s_axi_arvalid,
	input wire logic              s_axi_arready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic              s_axi_rvalid,
	input wire logic              s_axi_rready,
	input wire logic [31:0]       s_axi_rdata,
	input wire logic              s_axi_bvalid,
	input wire logic              s_axi_bready,
	input wire logic [1:0]        s_axi_bresp,
	// far side and outputs
	input wire sss_pkg::sss_tx_s  tx_state,
	input wire sss_pkg::sss_dma_s tx_dma,
	input wire sss_pkg::sss_dma_s rx_dma,
	input wire logic              transmitter_on,
	input wire logic              receiver_on,
	input wire logic              irq
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	////////////////////////////////////////////////////////////////////////
	// helpers
	wire logic st_rd = s_axi_arvalid && s_axi_arready
		&& s_axi_araddr[7:2] == 6'h00;
	wire logic tx_sent = !tx_state.holding_full && !tx_state.shifting;
	wire logic tz = tx_dma.count == 16'h0000 && tx_dma.next_count == 16'h0000;
	wire logic rz = rx_dma.count == 16'h0000 && rx_dma.next_count == 16'h0000;

	////////////////////////////////////////////////////////////////////////
	// assertions
	a_tx_free_flag: assert property (
		st_rd |=> s_axi_rdata[0] == !$past(tx_state.holding_full)
	) else $error("tx free flag wrong");
	a_tx_sent_flag: assert property (
		st_rd |=> s_axi_rdata[1] == $past(tx_sent)
	) else $error("tx all sent flag wrong");
	a_tx_zero_flag: assert property (
		st_rd |=> s_axi_rdata[3] == $past(tz)
	) else $error("tx counters zero flag wrong");
	a_rx_zero_flag: assert property (
		st_rd |=> s_axi_rdata[7] == $past(rz)
	) else $error("rx counters zero flag wrong");
	a_tx_on_bit: assert property (
		st_rd |=> s_axi_rdata[16] == $past(transmitter_on)
	) else $error("transmitter state bit wrong");
	a_rx_on_bit: assert property (
		st_rd |=> s_axi_rdata[17] == $past(receiver_on)
	) else $error("receiver state bit wrong");
	a_irq_reset_low: assert property (
		$rose(aresetn) |-> !irq
	) else $error("irq high after reset");
	a_read_answer: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
	) else $error("read answer late");
	a_read_hold: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
	) else $error("read data not held");
	a_resp_hold: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)
	) else $error("write response not held");

	// covers
	c_overrun: cover property (st_rd ##1 s_axi_rdata[5]);
	c_irq: cover property ($rose(irq));
	c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule : sss_status_irq_chk

bind sss_status_irq sss_status_irq_chk #(.ADDR_W(ADDR_W)) sss_status_irq_chk_inst (
	.aclk(aclk), .aresetn(aresetn), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.s_axi_rdata(s_axi_rdata), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
	.tx_state(tx_state), .tx_dma(tx_dma), .rx_dma(rx_dma),
	.transmitter_on(transmitter_on), .receiver_on(receiver_on), .irq(irq)
);

`default_nettype wire

/* File: verification/sss_far_model.sv */
`timescale 1ns/1ns
`default_nettype none

module sss_far_model (
	// clock
	input wire logic              aclk,
	// shifter, holding and dma state
	output var sss_pkg::sss_tx_s  tx_state,
	output var sss_pkg::sss_rx_s  rx_state,
	output var sss_pkg::sss_dma_s tx_dma,
	output var sss_pkg::sss_dma_s rx_dma,
	// frame sync levels
	output var logic              tx_frame_sync,
	output var logic              rx_frame_sync
);
	initial begin
		tx_state = '0;
		rx_state = '0;
		tx_dma = '0;
		rx_dma = '0;
		tx_frame_sync = 1'b0;
		rx_frame_sync = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// holding register and shifter levels
	task tx_set(input logic full, input logic shift);
		@(posedge aclk);
		tx_state <= '{full, shift};
	endtask : tx_set

	// one-cycle load or read strobe
	task rx_pulse(input logic ld, input logic rd);
		@(posedge aclk);
		rx_state <= '{ld, rd};
		@(posedge aclk);
		rx_state <= '0;
	endtask : rx_pulse

	// counter values, with a one-cycle write strobe
	// wr[0] counter write, wr[1] next-counter write
	task dma_set(input logic rx, input logic [15:0] c, input logic [15:0] n,
			input logic [1:0] wr);
		sss_pkg::sss_dma_s v;
		v = '{c, n, wr[0], wr[1]};
		@(posedge aclk);
		if (rx) rx_dma <= v;
		else tx_dma <= v;
		@(posedge aclk);
		v.count_wr = 1'b0;
		v.next_wr  = 1'b0;
		if (rx) rx_dma <= v;
		else tx_dma <= v;
	endtask : dma_set

	task fs_set(input logic t, input logic r);
		@(posedge aclk);
		tx_frame_sync <= t;
		rx_frame_sync <= r;
	endtask : fs_set
endmodule : sss_far_model

`default_nettype wire

/* File: verification/sss_status_irq_tb.sv */
`timescale 1ns/1ns
`default_nettype none

module sss_status_irq_tb;
	logic              aclk = 1'b0;
	logic              aresetn = 1'b0;
	logic              awv = 1'b0, wv = 1'b0, bre = 1'b0;
	logic              arv = 1'b0, rre = 1'b0;
	logic [7:0]        awa = 8'h00, ara = 8'h00;
	logic [31:0]       wd = 32'h00000000;
	logic              awr, wr, bv, arr, rv, ir, txo, rxo, fse;
	logic [1:0]        br, rr;
	logic [31:0]       rd, d;
	sss_pkg::sss_tx_s  tx_s;
	sss_pkg::sss_rx_s  rx_s;
	sss_pkg::sss_dma_s tx_d, rx_d;
	logic              tfs, rfs;
	logic              ce = 1'b1;
	int                n_mismatch = 0;
	int                cmp_count = 0;

	always #10 aclk = ~aclk;

	sss_status_irq #(.ADDR_W(8)) sss_status_irq_inst (
		.aclk(aclk), .aresetn(aresetn), .ce(ce),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
		.s_axi_awprot(3'h0), .s_axi_wvalid(wv), .s_axi_wready(wr),
		.s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_bvalid(bv),
		.s_axi_bready(bre), .s_axi_bresp(br), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
		.s_axi_rvalid(rv), .s_axi_rready(rre), .s_axi_rdata(rd),
		.s_axi_rresp(rr), .tx_state(tx_s), .rx_state(rx_s), .tx_dma(tx_d),
		.rx_dma(rx_d), .tx_frame_sync(tfs), .rx_frame_sync(rfs),
		.transmitter_on(txo), .receiver_on(rxo),
		.frame_sync_edge_select(fse), .irq(ir)
	);

	sss_far_model sss_far_model_inst (
		.aclk(aclk), .tx_state(tx_s), .rx_state(rx_s), .tx_dma(tx_d),
		.rx_dma(rx_d), .tx_frame_sync(tfs), .rx_frame_sync(rfs)
	);

	////////////////////////////////////////////////////////////////////////
	// reporting
	task give_verdict;
		$display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : give_verdict

	task cmp(input logic [31:0] g, input logic [31:0] e, input string m);
		cmp_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
		end
	endtask : cmp

	task hang;
		n_mismatch++;
		$display("wrong value at %0t: no bus answer", $time);
		give_verdict();
	endtask : hang

	////////////////////////////////////////////////////////////////////////
	// bus access
	task wr32(input logic [7:0] a, input logic [31:0] v,
			input logic [1:0] e = sss_pkg::RESP_OKAY);
		int n;
		@(posedge aclk);
		awv <= 1'b1;
		awa <= a;
		wv <= 1'b1;
		wd <= v;
		bre <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (awv && awr) awv <= 1'b0;
			if (wv && wr) wv <= 1'b0;
			if (bv) break;
		end
		bre <= 1'b0;
		if (n == 40) hang();
		cmp({30'h0, br}, {30'h0, e}, "write resp");
	endtask : wr32

	task rd32(input logic [7:0] a, input logic [1:0] e);
		int n;
		@(posedge aclk);
		arv <= 1'b1;
		ara <= a;
		rre <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (arv && arr) arv <= 1'b0;
			if (rv) break;
		end
		rre <= 1'b0;
		if (n == 40) hang();
		d = rd;
		cmp({30'h0, rr}, {30'h0, e}, "read resp");
	endtask : rd32

	task st(input logic [31:0] m, input logic [31:0] e);
		rd32(sss_pkg::OFF_STATUS, sss_pkg::RESP_OKAY);
		cmp(d & m, e, "status");
	endtask : st

	task mk(input logic [31:0] e);
		rd32(sss_pkg::OFF_IRQ_MASK, sss_pkg::RESP_OKAY);
		cmp(d, e, "mask");
	endtask : mk

	task irq_is(input logic e);
		@(negedge aclk);
		cmp({31'h0, ir}, {31'h0, e}, "irq");
	endtask : irq_is

	////////////////////////////////////////////////////////////////////////
	// sequence
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		st(32'hFFFFFFFF, 32'h0000008B);
		mk(32'h00000000);
		irq_is(1'b0);
		$display("test reset finished");
		wr32(sss_pkg::OFF_IRQ_EN, 32'hFFFFFFFF);
		mk(sss_pkg::IRQ_BITS);
		irq_is(1'b1);
		wr32(sss_pkg::OFF_IRQ_DIS, 32'h0000000F);
		mk(32'h00000CF0);
		wr32(sss_pkg::OFF_IRQ_DIS, 32'hFFFFFFFF);
		irq_is(1'b0);
		wr32(sss_pkg::OFF_IRQ_MASK, 32'hFFFFFFFF);
		mk(32'h00000000);
		wr32(8'h20, 32'hFFFFFFFF, sss_pkg::RESP_SLVERR);
		rd32(8'h20, sss_pkg::RESP_SLVERR);
		cmp(d, 32'h00000000, "unmapped");
		$display("test mask finished");
		wr32(sss_pkg::OFF_CTRL, 32'h01000003);
		cmp({30'h0, txo, rxo}, 32'h00000003, "enables");
		st(32'h00030000, 32'h00030000);
		cmp({31'h0, fse}, 32'h00000001, "edge select");
		sss_far_model_inst.fs_set(1'b1, 1'b1);
		st(32'h00000C00, 32'h00000800);
		st(32'h00000C00, 32'h00000000);
		sss_far_model_inst.fs_set(1'b0, 1'b0);
		st(32'h00000C00, 32'h00000400);
		st(32'h00000C00, 32'h00000000);
		wr32(sss_pkg::OFF_CTRL, 32'h00000001);
		cmp({30'h0, txo, rxo}, 32'h00000002, "enables");
		st(32'h00030000, 32'h00010000);
		sss_far_model_inst.fs_set(1'b1, 1'b0);
		st(32'h00000400, 32'h00000400);
		$display("test sync finished");
		sss_far_model_inst.tx_set(1'b1, 1'b0);
		st(32'h00000003, 32'h00000000);
		sss_far_model_inst.tx_set(1'b0, 1'b1);
		st(32'h00000003, 32'h00000001);
		sss_far_model_inst.tx_set(1'b0, 1'b0);
		st(32'h00000003, 32'h00000003);
		sss_far_model_inst.dma_set(1'b0, 16'h0005, 16'h0000, 2'h1);
		st(32'h0000000C, 32'h00000000);
		sss_far_model_inst.dma_set(1'b0, 16'h0000, 16'h0000, 2'h0);
		st(32'h0000000C, 32'h0000000C);
		sss_far_model_inst.dma_set(1'b0, 16'h0000, 16'h0003, 2'h2);
		st(32'h0000000C, 32'h00000000);
		$display("test transmit finished");
		sss_far_model_inst.rx_pulse(1'b1, 1'b0);
		st(32'h00000030, 32'h00000010);
		sss_far_model_inst.rx_pulse(1'b1, 1'b0);
		st(32'h00000030, 32'h00000030);
		st(32'h00000030, 32'h00000010);
		sss_far_model_inst.rx_pulse(1'b0, 1'b1);
		st(32'h00000010, 32'h00000000);
		sss_far_model_inst.dma_set(1'b1, 16'h0002, 16'h0000, 2'h1);
		st(32'h000000C0, 32'h00000000);
		sss_far_model_inst.dma_set(1'b1, 16'h0000, 16'h0000, 2'h0);
		st(32'h000000C0, 32'h000000C0);
		sss_far_model_inst.dma_set(1'b1, 16'h0000, 16'h0000, 2'h2);
		st(32'h000000C0, 32'h00000080);
		$display("test receive finished");
		wr32(sss_pkg::OFF_IRQ_EN, 32'h00000020);
		irq_is(1'b0);
		sss_far_model_inst.rx_pulse(1'b1, 1'b0);
		sss_far_model_inst.rx_pulse(1'b1, 1'b0);
		irq_is(1'b1);
		st(32'h00000020, 32'h00000020);
		irq_is(1'b0);
		sss_far_model_inst.rx_pulse(1'b1, 1'b0);
		irq_is(1'b1);
		wr32(sss_pkg::OFF_STATUS, 32'h00000020);
		irq_is(1'b0);
		@(posedge aclk);
		ce <= 1'b0;
		sss_far_model_inst.rx_pulse(1'b0, 1'b1);
		@(posedge aclk);
		ce <= 1'b1;
		st(32'h00000010, 32'h00000010);
		$display("test interrupt finished");
		give_verdict();
	end
endmodule : sss_status_irq_tb

`default_nettype wire
